/* File: rtl/synth_pll_cfg.svh */
// Constants for the synthesizer mode and status control block.
// Assumes a single 10 MHz clock; included by its bare name.
`ifndef SYNTH_PLL_CFG_SVH
`define SYNTH_PLL_CFG_SVH

// ----------------------------------------------------------------
// Field widths
// ----------------------------------------------------------------
`define FB_INT_W        8
`define FB_FRAC_W       27
`define FB_RATIO_W      35
`define FREQ_WORD_W     32
`define XTAL_TRIM_W     24
`define CAP_SEL_W       6
`define FILT_SEL_W      4
`define RELEASE_W       4

// ----------------------------------------------------------------
// Scaling: frequency word LSB is 2^-40 of the ratio
// ----------------------------------------------------------------
`define FREQ_LSB_SHIFT  40

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define STARTUP_IMMEDIATE 2'h0
`define RELEASE_NONE      4'h0
`define RELEASE_ALL       4'hF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS   100
`define STAGE_TIME_NS   1000
`define STAGE_CYCLES    ((`STAGE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CAL_TIMEOUT_NS  100000
`define CAL_CYCLES      (`CAL_TIMEOUT_NS / `CLK_PERIOD_NS)
`define SDM_DIV         4
`define TIMER_W         12
`define TICK_W          3

`endif

/* File: rtl/synth_pll_pkg.sv */
// Types shared by the synthesizer mode and status control block.
// Assumes synth_pll_cfg.svh is available on the include path.
`include "synth_pll_cfg.svh"

package synth_pll_pkg;

   // ----------------------------------------------------------------
   // Modes and sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {
      MODE_SYNTH        = 1'b0,
      MODE_JITTER_CLEAN = 1'b1
   } op_mode_t;

   typedef enum logic [1:0] {
      SEQ_HOLD    = 2'b00,
      SEQ_CAL     = 2'b01,
      SEQ_RELEASE = 2'b10,
      SEQ_RUN     = 2'b11
   } seq_state_t;

   // ----------------------------------------------------------------
   // Analog configuration carrier
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                    ref_single_ended;
      logic                    diff_ac_bias_enable;
      logic                    selfbias_enable;
      logic                    ref_pad_enable;
      logic                    doubler_enable;
      logic                    doubler_src_ref;
      logic [`CAP_SEL_W-1:0]   xin_cap_select;
      logic [`CAP_SEL_W-1:0]   xout_cap_select;
      logic [`FILT_SEL_W-1:0]  filter_r1_select;
      logic [`FILT_SEL_W-1:0]  filter_cp_select;
      logic [`FILT_SEL_W-1:0]  filter_r3_select;
      logic [`FILT_SEL_W-1:0]  filter_c3_select;
      logic                    third_pole_bypass;
   } analog_cfg_t;

   // Mode-entry bits from the host
   typedef struct packed {
      logic       input_buffer_enable;
      logic [1:0] out_startup;
      logic       lock_source_sel;
      logic       digital_loop_enable;
   } mode_bits_t;

   // ----------------------------------------------------------------
   // Whole state of the control block
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0]                lock_sync;
      logic [2:0]                regok_sync;
      logic [2:0]                caldone_sync;
      logic [2:0]                calfail_sync;
      logic                      lock_stable;
      logic                      regok_stable;
      logic                      caldone_stable;
      logic                      calfail_stable;
      logic                      lock_status;
      logic                      lock_gpio;
      logic                      loss_of_lock;
      seq_state_t                seq;
      logic [`TIMER_W-1:0]       timer;
      logic [`RELEASE_W-1:0]     release_blocks;
      logic                      cal_start;
      logic                      cal_done;
      logic                      cal_fail;
      op_mode_t                  mode;
      logic                      digital_loop_on;
      logic [`FREQ_WORD_W-1:0]   freq_word;
      logic [`FB_RATIO_W-1:0]    fb_ratio;
      logic [`FB_FRAC_W-1:0]     sdm_acc;
      logic [`FB_INT_W-1:0]      mmd_ratio;
      logic [`TICK_W-1:0]        tick_cnt;
      analog_cfg_t               analog;
   } state_t;

endpackage : synth_pll_pkg

/* File: rtl/synth_pll_mode_control.sv */
// Digital mode, divider-word and status control of a clock synthesizer.
// Assumes host configuration arrives as plain levels on the clk domain,
// while lock, regulator and calibration indications are asynchronous.
`timescale 1ns/1ps
`include "synth_pll_cfg.svh"

module synth_pll_mode_control (
   input  wire logic                          clk,               // 10 MHz
   input  wire logic                          rstn,              // Async
   input  wire synth_pll_pkg::mode_bits_t     mode_bits,         // Entry bits
   input  wire synth_pll_pkg::analog_cfg_t    analog_cfg,        // Analog set
   input  wire logic [`FB_INT_W-1:0]          feedback_ratio_integer, // Int
   input  wire logic [`FB_FRAC_W-1:0]         feedback_ratio_fraction, // Frac
   input  wire logic [`FREQ_WORD_W-1:0]       freq_word,         // Signed
   input  wire logic                          freq_word_write,   // Strobe
   input  wire logic [`XTAL_TRIM_W-1:0]       xtal_trim,         // Signed
   input  wire logic                          lol_write,         // Strobe
   input  wire logic                          lol_write_data,    // 1 clears
   input  wire logic                          lock_gpio_enable,  // Route lock
   input  wire logic                          lock_detect_pin,   // Async
   input  wire logic                          regulator_ok_pin,  // Async
   input  wire logic                          bias_cal_done_pin, // Async
   input  wire logic                          bias_cal_fail_pin, // Async
   output logic                               jitter_clean_mode, // Mode
   output logic                               digital_loop_on,   // DPLL run
   output logic                               digital_loop_bypass, // Bypass
   output logic [`RELEASE_W-1:0]              block_release,     // Per block
   output logic                               bias_cal_start,    // Cal go
   output logic                               bias_cal_done,     // Flag
   output logic                               bias_cal_fail,     // Flag
   output logic                               lock_status,       // Level
   output logic                               lock_gpio,         // Pin
   output logic                               loss_of_lock,      // Sticky
   output logic [`FB_RATIO_W-1:0]             applied_ratio,     // Scaled
   output logic [`FB_INT_W-1:0]               multi_ratio_divider, // Step
   output synth_pll_pkg::analog_cfg_t         analog_out         // To analog
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Three-stage chain; first stage only feeds the second
   function automatic logic [2:0] sync_shift(input logic [2:0] chain,
                                             input logic       pin);
      sync_shift = {chain[1:0], pin};
   endfunction : sync_shift

   // A change is accepted once the second and third stages agree
   function automatic logic sync_settle(input logic [2:0] chain,
                                        input logic       prev);
      sync_settle = (chain[1] == chain[2]) ? chain[2] : prev;
   endfunction : sync_settle

   // Apply offset (LSB 2^-40 of ratio) to the ratio, fraction in 2^-27
   function automatic logic [`FB_RATIO_W-1:0] scale_ratio(
      input logic [`FB_RATIO_W-1:0]  ratio,
      input logic signed [`FREQ_WORD_W:0] offset);
      logic signed [`FB_RATIO_W+`FREQ_WORD_W+1:0] prod;
      logic signed [`FB_RATIO_W:0]               sum;
      prod = $signed({1'b0, ratio}) * offset;
      sum  = $signed({1'b0, ratio})
           + $signed(prod[`FB_RATIO_W+`FREQ_WORD_W+1:`FREQ_LSB_SHIFT]);
      scale_ratio = sum[`FB_RATIO_W-1:0];
   endfunction : scale_ratio

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   localparam logic [`TIMER_W-1:0] STAGE_LIMIT = `TIMER_W'(`STAGE_CYCLES);
   localparam logic [`TIMER_W-1:0] CAL_LIMIT   = `TIMER_W'(`CAL_CYCLES);
   localparam logic [`TICK_W-1:0]  TICK_LIMIT  = `TICK_W'(`SDM_DIV - 1);

   synth_pll_pkg::state_t s_q;
   synth_pll_pkg::state_t s_d;

   logic                               enter_jc;
   logic                               lock_fell;
   logic                               sdm_tick;
   logic                               frac_is_zero;
   logic signed [`FREQ_WORD_W:0]       offset_sum;
   logic [`FB_RATIO_W-1:0]             base_ratio;
   logic [`FB_FRAC_W:0]                acc_sum;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;

      // Input synchronisers for asynchronous indications
      s_d.lock_sync      = sync_shift(s_q.lock_sync, lock_detect_pin);
      s_d.regok_sync     = sync_shift(s_q.regok_sync, regulator_ok_pin);
      s_d.caldone_sync   = sync_shift(s_q.caldone_sync, bias_cal_done_pin);
      s_d.calfail_sync   = sync_shift(s_q.calfail_sync, bias_cal_fail_pin);
      s_d.lock_stable    = sync_settle(s_q.lock_sync, s_q.lock_stable);
      s_d.regok_stable   = sync_settle(s_q.regok_sync, s_q.regok_stable);
      s_d.caldone_stable = sync_settle(s_q.caldone_sync, s_q.caldone_stable);
      s_d.calfail_stable = sync_settle(s_q.calfail_sync, s_q.calfail_stable);

      // Lock status and its optional routing to an output pin
      s_d.lock_status = s_q.lock_stable;
      s_d.lock_gpio   = s_q.lock_stable & lock_gpio_enable;

      // Sticky loss-of-lock; a new falling edge wins over a clear
      lock_fell = s_q.lock_status & ~s_q.lock_stable;
      if (lock_fell) begin
         s_d.loss_of_lock = 1'b1;
      end else if (lol_write && lol_write_data) begin
         s_d.loss_of_lock = 1'b0;
      end

      // Power-up sequencer and bias calibration
      case (s_q.seq)
         synth_pll_pkg::SEQ_HOLD: begin
            s_d.release_blocks = `RELEASE_NONE;
            s_d.timer          = '0;
            if (s_q.regok_stable) begin
               s_d.release_blocks = `RELEASE_W'(1);         // Bias first
               s_d.cal_start      = 1'b1;
               s_d.seq            = synth_pll_pkg::SEQ_CAL;
            end
         end
         synth_pll_pkg::SEQ_CAL: begin
            s_d.timer = s_q.timer + `TIMER_W'(1);
            // Failure or timeout still lets startup proceed
            if (s_q.calfail_stable || s_q.timer == CAL_LIMIT) begin
               s_d.cal_fail  = 1'b1;
               s_d.cal_start = 1'b0;
               s_d.timer     = '0;
               s_d.seq       = synth_pll_pkg::SEQ_RELEASE;
            end else if (s_q.caldone_stable) begin
               s_d.cal_done  = 1'b1;
               s_d.cal_start = 1'b0;
               s_d.timer     = '0;
               s_d.seq       = synth_pll_pkg::SEQ_RELEASE;
            end
         end
         synth_pll_pkg::SEQ_RELEASE: begin
            s_d.timer = s_q.timer + `TIMER_W'(1);
            if (s_q.timer == STAGE_LIMIT) begin
               s_d.timer          = '0;
               s_d.release_blocks = {s_q.release_blocks[`RELEASE_W-2:0],
                                     1'b1};
               if (s_d.release_blocks == `RELEASE_ALL) begin
                  s_d.seq = synth_pll_pkg::SEQ_RUN;
               end
            end
         end
         synth_pll_pkg::SEQ_RUN: begin
            s_d.timer = '0;
         end
         default: begin
            s_d.seq = synth_pll_pkg::SEQ_HOLD;
         end
      endcase

      // Regulators dropping returns the sequencer to hold, clearing all releases and cal start
      if (!s_q.regok_stable) begin
         s_d.seq            = synth_pll_pkg::SEQ_HOLD;
         s_d.release_blocks = `RELEASE_NONE;
         s_d.cal_start      = 1'b0;
      end

      // Mode selection: all four entry bits needed
      enter_jc = mode_bits.input_buffer_enable
               & mode_bits.lock_source_sel
               & mode_bits.digital_loop_enable
               & (mode_bits.out_startup != `STARTUP_IMMEDIATE);
      s_d.mode = enter_jc ? synth_pll_pkg::MODE_JITTER_CLEAN
                          : synth_pll_pkg::MODE_SYNTH;
      // Digital loop only runs in jitter-clean mode, saving power
      s_d.digital_loop_on = enter_jc & s_q.release_blocks[2];

      // Frequency word is only taken in synthesizer mode
      if (freq_word_write &&
          s_q.mode == synth_pll_pkg::MODE_SYNTH) begin
         s_d.freq_word = freq_word;
      end

      // Dynamic word (synthesizer mode only) plus crystal trim, both LSB 2^-40
      offset_sum = $signed(`XTAL_TRIM_W'(xtal_trim))
                 + ((s_q.mode == synth_pll_pkg::MODE_SYNTH)
                    ? $signed({s_q.freq_word[`FREQ_WORD_W-1],
                               s_q.freq_word})
                    : $signed({(`FREQ_WORD_W+1){1'b0}}));
      base_ratio = {feedback_ratio_integer,
                    feedback_ratio_fraction};
      s_d.fb_ratio = scale_ratio(base_ratio, offset_sum);

      // First-order modulator picks the integer step per update
      s_d.tick_cnt = (s_q.tick_cnt == TICK_LIMIT) ? '0
                   : s_q.tick_cnt + `TICK_W'(1);
      sdm_tick = (s_q.tick_cnt == TICK_LIMIT) & s_q.release_blocks[1];
      acc_sum  = {1'b0, s_q.sdm_acc}
               + {1'b0, s_q.fb_ratio[`FB_FRAC_W-1:0]};
      if (sdm_tick) begin
         s_d.sdm_acc   = acc_sum[`FB_FRAC_W-1:0];
         s_d.mmd_ratio = s_q.fb_ratio[`FB_RATIO_W-1:`FB_FRAC_W]
                       + `FB_INT_W'(acc_sum[`FB_FRAC_W]);
      end

      // Analog configuration fields passed to the analog macros
      s_d.analog = analog_cfg;
      s_d.analog.doubler_enable  = analog_cfg.doubler_enable;
      s_d.analog.doubler_src_ref = analog_cfg.doubler_src_ref;
      // Pad stays off until the host enables the input buffer
      s_d.analog.ref_pad_enable = mode_bits.input_buffer_enable;
      // Bias choice follows the buffer type the host selected
      s_d.analog.diff_ac_bias_enable = analog_cfg.diff_ac_bias_enable
                                     & ~analog_cfg.ref_single_ended;
      s_d.analog.selfbias_enable = analog_cfg.selfbias_enable
                                 & analog_cfg.ref_single_ended;
      // Guard: a bypass with a live fraction would upset the loop
      frac_is_zero = (s_q.fb_ratio[`FB_FRAC_W-1:0] == '0);
      s_d.analog.third_pole_bypass = analog_cfg.third_pole_bypass
                                   & frac_is_zero;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, each straight from the state register
   // ----------------------------------------------------------------
   assign jitter_clean_mode   = s_q.mode;
   assign digital_loop_on     = s_q.digital_loop_on;
   assign digital_loop_bypass = ~s_q.mode;
   assign block_release       = s_q.release_blocks;
   assign bias_cal_start      = s_q.cal_start;
   assign bias_cal_done       = s_q.cal_done;
   assign bias_cal_fail       = s_q.cal_fail;
   assign lock_status         = s_q.lock_status;
   assign lock_gpio           = s_q.lock_gpio;
   assign loss_of_lock        = s_q.loss_of_lock;
   assign applied_ratio       = s_q.fb_ratio;
   assign multi_ratio_divider = s_q.mmd_ratio;
   assign analog_out          = s_q.analog;

endmodule : synth_pll_mode_control

/* File: sim/synth_pll_mode_asserts.sv */
// Checker bound to the synthesizer mode control block.
// Assumes the block's port names and synth_pll_cfg.svh widths.
`timescale 1ns/1ps
`include "synth_pll_cfg.svh"

module synth_pll_mode_asserts (
   input wire logic                       clk,         // Clock
   input wire logic                       rstn,        // Reset
   input wire synth_pll_pkg::mode_bits_t  mode_bits,   // Entry bits
   input wire logic [`FB_INT_W-1:0]       feedback_ratio_integer,  // Int
   input wire logic [`FB_FRAC_W-1:0]      feedback_ratio_fraction, // Frac
   input wire logic [`XTAL_TRIM_W-1:0]    xtal_trim,   // Trim
   input wire logic                       lol_write,   // Strobe
   input wire logic                       lol_write_data,      // Data
   input wire logic                       jitter_clean_mode,   // Mode
   input wire logic                       digital_loop_on,     // Loop
   input wire logic                       digital_loop_bypass, // Bypass
   input wire logic [`RELEASE_W-1:0]      block_release, // Release
   input wire logic                       lock_status,   // Lock
   input wire logic                       loss_of_lock,  // Sticky
   input wire logic [`FB_RATIO_W-1:0]     applied_ratio, // Ratio
   input wire synth_pll_pkg::analog_cfg_t analog_out     // Analog
);
   logic                  jc_req;
   logic [`FB_FRAC_W-1:0] applied_frac;
   // All four entry bits are needed; any one missing keeps synth mode
   assign jc_req = mode_bits.input_buffer_enable && mode_bits.lock_source_sel
      && mode_bits.digital_loop_enable && (mode_bits.out_startup != 2'h0);
   assign applied_frac = applied_ratio[`FB_FRAC_W-1:0];
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // Long enough in jitter-clean mode for the ratio pipe to settle
   sequence s_quiet;
      (jitter_clean_mode && $stable({feedback_ratio_integer,
         feedback_ratio_fraction, xtal_trim}))[*4];
   endsequence
   mode_entry_a: assert property (
      ##1 jitter_clean_mode == $past(jc_req)) else $error("mode flag wrong");
   bypass_mode_a: assert property (
      digital_loop_bypass == !jitter_clean_mode) else $error("bypass wrong");
   loop_gate_a: assert property (
      digital_loop_on |-> block_release[2]) else $error("loop on early");
   bias_pick_a: assert property (
      (analog_out.diff_ac_bias_enable |-> !analog_out.ref_single_ended) and
      (analog_out.selfbias_enable |-> analog_out.ref_single_ended))
      else $error("bias enable on wrong input type");
   pole_bypass_a: assert property (
      analog_out.third_pole_bypass |-> $past(applied_frac) == 27'h0)
      else $error("bypass with nonzero fraction");
   word_ignored_a: assert property (
      s_quiet |-> $stable(applied_ratio)) else $error("word applied");
   lol_set_a: assert property (
      $fell(lock_status) |-> loss_of_lock) else $error("lock loss missed");
   // A fall landing on the clear edge wins, so it is left out here
   lol_clear_a: assert property (
      lol_write && lol_write_data ##1 !$fell(lock_status) |-> !loss_of_lock)
      else $error("event not cleared");
   release_order_a: assert property (
      block_release inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
      else $error("release out of order");
endmodule : synth_pll_mode_asserts

bind synth_pll_mode_control synth_pll_mode_asserts chk_u (.clk(clk),
   .rstn(rstn), .mode_bits(mode_bits), .xtal_trim(xtal_trim),
   .feedback_ratio_integer(feedback_ratio_integer),
   .feedback_ratio_fraction(feedback_ratio_fraction),
   .lol_write(lol_write), .lol_write_data(lol_write_data),
   .jitter_clean_mode(jitter_clean_mode), .digital_loop_on(digital_loop_on),
   .digital_loop_bypass(digital_loop_bypass), .block_release(block_release),
   .lock_status(lock_status), .loss_of_lock(loss_of_lock),
   .applied_ratio(applied_ratio), .analog_out(analog_out));

/* File: sim/host_model.sv */
// Host model: serial-port writes seen as one-cycle strobes.
// Assumes the bench calls its tasks from the clk domain.
`timescale 1ns/1ps
`include "synth_pll_cfg.svh"

module host_model (
   output logic [`FREQ_WORD_W-1:0] freq_word,       // Word
   output logic                    freq_word_write, // Strobe
   output logic                    lol_write,       // Strobe
   output logic                    lol_write_data,  // Data
   input  wire logic               clk              // Clock
);
   // Idle lines at time zero
   initial begin
      freq_word = '0;
      freq_word_write = 1'h0;
      lol_write = 1'h0;
      lol_write_data = 1'h0;
   end
   // Data flips after the strobe, so a late sample cannot pass
   task automatic put_word(input logic [`FREQ_WORD_W-1:0] w);
      @(posedge clk);
      freq_word       <= w;
      freq_word_write <= 1'h1;
      @(posedge clk);
      freq_word       <= ~w;
      freq_word_write <= 1'h0;
   endtask : put_word
   task automatic put_lol(input logic d);
      @(posedge clk);
      lol_write_data <= d;
      lol_write      <= 1'h1;
      @(posedge clk);
      lol_write_data <= ~d;
      lol_write      <= 1'h0;
   endtask : put_lol
endmodule : host_model

/* File: sim/synth_pll_mode_control_test.sv */
// Self-checking bench for the synthesizer mode control block.
// Assumes host_model and the bound checker are compiled with it.
`timescale 1ns/1ps
`include "synth_pll_cfg.svh"

module synth_pll_mode_control_test;
   synth_pll_pkg::mode_bits_t  mb = '0;
   synth_pll_pkg::analog_cfg_t ac = '0, aout;
   logic [`FB_INT_W-1:0]       r_int = 8'h40, mrd;
   logic [`FB_FRAC_W-1:0]      r_frac = '0;
   logic [`XTAL_TRIM_W-1:0]    trim = '0;
   logic [`FB_RATIO_W-1:0]     ratio;
   logic [`FREQ_WORD_W-1:0]    fw;
   logic [`RELEASE_W-1:0]      rel;
   logic clk = 1'h0, rstn = 1'h0, lge = 1'h0, lk_pin = 1'h0;
   logic reg_ok = 1'h0, c_ok = 1'h0, c_bad = 1'h0;
   logic fw_wr, lw, lwd, jc, dl_on, byp, go, c_d, c_f, lk, lk_io, lol;
   int   n_errors = 0, num_checks = 0;

   // 10 MHz clock
   always #50 clk = ~clk;
   host_model host_u (.clk(clk), .freq_word(fw), .freq_word_write(fw_wr),
      .lol_write(lw), .lol_write_data(lwd));
   synth_pll_mode_control dut_u (.clk(clk), .rstn(rstn), .mode_bits(mb),
      .analog_cfg(ac), .feedback_ratio_integer(r_int), .xtal_trim(trim),
      .feedback_ratio_fraction(r_frac), .freq_word(fw),
      .freq_word_write(fw_wr), .lol_write(lw), .lol_write_data(lwd),
      .lock_gpio_enable(lge), .lock_detect_pin(lk_pin),
      .regulator_ok_pin(reg_ok), .bias_cal_done_pin(c_ok),
      .bias_cal_fail_pin(c_bad), .jitter_clean_mode(jc),
      .digital_loop_on(dl_on), .digital_loop_bypass(byp),
      .block_release(rel), .bias_cal_start(go), .bias_cal_done(c_d),
      .bias_cal_fail(c_f), .lock_status(lk), .lock_gpio(lk_io),
      .loss_of_lock(lol), .applied_ratio(ratio),
      .multi_ratio_divider(mrd), .analog_out(aout));

   // ---------------------------------------------
   // Shared helpers
   // ---------------------------------------------
   task automatic check(input string what, input logic [63:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Sample 1 ns after the edge, once its updates have landed
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   // Ratio in 2^-27 units plus its scaled offset, floored
   function automatic logic [`FB_RATIO_W-1:0] exp_ratio(input longint off);
      longint base;
      base = (longint'(r_int) <<< `FB_FRAC_W) + longint'(r_frac);
      return `FB_RATIO_W'(base + ((base * off) >>> `FREQ_LSB_SHIFT));
   endfunction : exp_ratio
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test

   // Reset, regulator hold-off, then calibration pass or fail
   task automatic t_startup(input logic bad);
      @(posedge clk);
      rstn   <= 1'h0;
      reg_ok <= 1'h0;
      c_ok   <= ~bad;
      c_bad  <= bad;
      tick(6);
      check("reset mode", {jc, byp, aout.ref_pad_enable}, 3'h2);
      @(posedge clk);
      rstn <= 1'h1;
      tick(8);
      check("held", rel, 4'h0);
      @(posedge clk);
      reg_ok <= 1'h1;
      tick(8);
      check("first release", rel, 4'h1);
      for (int i = 0; i < 100 && rel !== 4'hF; i++) tick(1);
      check("all released", rel, 4'hF);
      check("cal flags", {c_d, c_f, go}, {~bad, bad, 1'h0});
      $display("startup test done");
   endtask : t_startup
   task automatic t_dco();
      host_u.put_word(32'h0000_8000);
      tick(3);
      check("word", ratio, exp_ratio(32768));
      @(posedge clk);
      trim   <= 24'hFFFF80;
      r_int  <= 8'h5A;
      r_frac <= 27'h0000123;
      tick(4);
      check("trim", ratio, exp_ratio(32768 - 128));
      host_u.put_word(32'hFFFF_8000);
      tick(3);
      check("neg word", ratio, exp_ratio(-32768 - 128));
      $display("dco test done");
   endtask : t_dco
   task automatic t_jitter();
      logic [4:0] code [7] = '{5'h1F, 5'h17, 5'h1B, 5'h0F, 5'h13, 5'h1D, 5'h1E};
      for (int i = 0; i < 7; i++) begin
         @(posedge clk);
         mb <= code[i];
         tick(2);
         check("mode", {jc, byp}, {i < 3, i >= 3});
         check("loop on", dl_on, i < 3);
         check("pad", aout.ref_pad_enable, code[i][4]);
      end
      @(posedge clk);
      mb <= 5'h1F;
      tick(4);
      host_u.put_word(32'h0100_0000);
      tick(3);
      check("jc ratio", ratio, exp_ratio(-128));
      @(posedge clk);
      mb <= 5'h00;
      tick(4);
      check("word kept", ratio, exp_ratio(-32768 - 128));
      $display("jitter test done");
   endtask : t_jitter
   task automatic t_lock();
      @(posedge clk);
      lge    <= 1'h1;
      lk_pin <= 1'h1; // Detector range taken as matched
      tick(8);
      check("locked", {lk, lk_io, lol}, 3'h6);
      @(posedge clk);
      lge    <= 1'h0;
      lk_pin <= 1'h0;
      tick(8);
      check("lost", {lk, lk_io, lol}, 3'h1);
      @(posedge clk);
      lk_pin <= 1'h1;
      host_u.put_lol(1'h0);
      tick(8);
      check("kept", lol, 1'h1);
      host_u.put_lol(1'h1);
      tick(2);
      check("cleared", lol, 1'h0);
      $display("lock test done");
   endtask : t_lock
   task automatic t_analog();
      int ones = 0;
      host_u.put_word(32'h0);
      @(posedge clk);
      trim   <= 24'h0;
      r_frac <= 27'h0;
      ac <= {6'h3E, 6'h2A, 6'h15, 16'h359C, 1'h1};
      tick(4);
      check("single", aout, {6'h2A, 6'h2A, 6'h15, 16'h359C, 1'h1});
      @(posedge clk);
      ac <= {6'h1D, 6'h01, 6'h3E, 16'hA60F, 1'h1};
      tick(4);
      check("diff", aout, {6'h11, 6'h01, 6'h3E, 16'hA60F, 1'h1});
      @(posedge clk);
      r_frac <= 27'h2000000;
      tick(4);
      check("bypass off", aout.third_pole_bypass, 1'h0);
      for (int i = 0; i < 64; i++) begin
         tick(1);
         ones += (mrd === r_int + 8'h1) ? 16 : (mrd === r_int) ? 0 : 4096;
      end
      check("carries", ones >= 192 && ones <= 320, 1'h1);
      $display("analog test done");
   endtask : t_analog

   initial begin
      t_startup(1'h1);
      t_startup(1'h0);
      t_dco();
      t_jitter();
      t_lock();
      t_analog();
      end_of_test();
   end
   // Watchdog well past the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      end_of_test();
   end
endmodule : synth_pll_mode_control_test
